// [hw/etd_timer.v]
/*
 * Two 8-bit timer channels with interval, event count and divider modes, on APB.
 * Assumes pclk is the machine clock and event pins are asynchronous to it.
 */
// Contract
// - Timer mode counts prescaled clock; match pulses irq, clears counter, continues.
// - Event mode counts input falling edges; match pulses irq, clears, resumes.
// - Match register has no buffer; writes take effect at once.
// - Divider match inverts flip-flop, clears counter, raises irq together.
// - Divider output pin is inverse of flip-flop, giving 50 percent square wave.
// - Flip-flop loads the written init bit only while the channel is stopped; reset clears it.
// - Stopped channel holds pin level; bit change only after the stop.
// - Clearing bit 3 stops; later clearing bit 7 forces pin high.
// - Mode 000 is timer or event counter, 001 is divider.
// - Clock select picks prescaled clocks, sub, main/2, main, or 111 pin.
// - Clearing run bit stops and clears counter; setting it starts counting.
`timescale 1ns/1ps
`default_nettype none
`include "etd_defines.vh"

module etd_timer (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Oscillator ticks, one pclk cycle wide, from the clock generator.
  input wire main_osc_tick,
  input wire sub_osc_tick,
  // Pins.
  input wire [1:0] event_in_pin,
  output reg [1:0] divider_out_pin_n,
  output reg [1:0] match_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Shared prescaler on the main oscillator and the sub oscillator.
  reg [10:0] pre_q;
  reg [2:0] sub_pre_q;
  reg presrc_q;
  wire [10:0] pre_inc;
  wire [2:0] sub_inc;
  assign pre_inc = pre_q + 11'h001;
  assign sub_inc = sub_pre_q + 3'h1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 11'h000;
      sub_pre_q <= 3'h0;
    end else begin
      if (main_osc_tick) begin
        pre_q <= pre_inc;
      end
      if (sub_osc_tick) begin
        sub_pre_q <= sub_inc;
      end
    end
  end

  // Divider carries: rate n ticks when the low n bits roll over.
  wire t1;
  wire t3;
  wire t5;
  wire t7;
  wire t11;
  wire ts3;
  assign t1 = main_osc_tick & pre_q[0];
  assign t3 = main_osc_tick & (&pre_q[2:0]);
  assign t5 = main_osc_tick & (&pre_q[4:0]);
  assign t7 = main_osc_tick & (&pre_q[6:0]);
  assign t11 = main_osc_tick & (&pre_q[10:0]);
  assign ts3 = sub_osc_tick & (&sub_pre_q);

  ////////////////////////////////////////////////////////////////////////////
  // APB access decode; every access is answered in its second access cycle, after one wait state.
  wire acc;
  wire wr;
  assign acc = psel & penable & ~pready;
  assign wr = acc & pwrite;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presrc_q <= 1'b0;
    end else if (wr && paddr == `ETD_OFS_PRESRC) begin
      presrc_q <= pwdata[0];
    end
  end

  wire [7:0] ctrl_w [0:1];
  wire [7:0] match_w [0:1];
  wire [7:0] cnt_w [0:1];
  wire ff_w [0:1];

  ////////////////////////////////////////////////////////////////////////////
  // Channels.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : ch
      reg [7:0] ctrl_q;
      reg [7:0] match_q;
      reg [7:0] cnt_q;
      reg ff_q;
      reg sync1_q;
      reg sync2_q;
      reg prev_q;
      reg tick;
      wire ctrl_hit;
      wire match_hit;
      wire run;
      wire [2:0] ck;
      wire [2:0] mode;
      wire hit;
      assign ctrl_hit = wr && paddr == (g ? `ETD_OFS_CTRL1 : `ETD_OFS_CTRL0);
      assign match_hit = wr && paddr == (g ? `ETD_OFS_MATCH1 : `ETD_OFS_MATCH0);
      assign run = ctrl_q[`ETD_RUN_BIT];
      assign ck = ctrl_q[`ETD_CK_MSB:`ETD_CK_LSB];
      assign mode = ctrl_q[`ETD_MODE_MSB:`ETD_MODE_LSB];

      // Clock select decode; code 000 follows the prescale source choice.
      always @* begin
        case (ck)
          3'h0: tick = presrc_q ? ts3 : t11;
          3'h1: tick = t7;
          3'h2: tick = t5;
          3'h3: tick = t3;
          3'h4: tick = sub_osc_tick;
          3'h5: tick = t1;
          3'h6: tick = main_osc_tick;
          3'h7: tick = prev_q & ~sync2_q;
          default: tick = 1'b0;
        endcase
      end

      // Count hits the match value on a counting tick.
      assign hit = run && tick && (cnt_q + 8'h01 == match_q);

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl_q <= `ETD_CTRL_RST;
          match_q <= `ETD_MATCH_RST;
          cnt_q <= 8'h00;
          ff_q <= 1'b0;
          sync1_q <= 1'b1;
          sync2_q <= 1'b1;
          prev_q <= 1'b1;
          match_irq[g] <= 1'b0;
          divider_out_pin_n[g] <= 1'b1;
        end else begin
          sync1_q <= event_in_pin[g];
          sync2_q <= sync1_q;
          prev_q <= sync2_q;
          if (match_hit) begin
            match_q <= pwdata[7:0];
          end
          if (ctrl_hit) begin
            ctrl_q <= pwdata[7:0];
          end
          match_irq[g] <= hit;
          if (!run) begin
            cnt_q <= 8'h00;
          end else if (hit) begin
            cnt_q <= 8'h00;
          end else if (tick) begin
            cnt_q <= cnt_q + 8'h01;
          end
          if (ctrl_hit && !pwdata[`ETD_RUN_BIT] && !run) begin
            ff_q <= pwdata[`ETD_FF_BIT];
          end else if (ctrl_hit && pwdata[`ETD_RUN_BIT] && !run) begin
            ff_q <= pwdata[`ETD_FF_BIT];
          end else if (hit && mode == `ETD_MODE_DIV) begin
            ff_q <= ~ff_q;
          end
          divider_out_pin_n[g] <= ~ff_q;
        end
      end
      assign ctrl_w[g] = ctrl_q;
      assign match_w[g] = match_q;
      assign cnt_w[g] = cnt_q;
      assign ff_w[g] = ff_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read data for every read, ready and error for every access.
  reg [31:0] rd;
  reg known;
  always @* begin
    rd = 32'h00000000;
    known = 1'b1;
    case (paddr)
      `ETD_OFS_CTRL0: rd = {24'h000000, ctrl_w[0]};
      `ETD_OFS_MATCH0: rd = {24'h000000, match_w[0]};
      `ETD_OFS_STAT0: rd = {23'h000000, ff_w[0], cnt_w[0]};
      `ETD_OFS_CTRL1: rd = {24'h000000, ctrl_w[1]};
      `ETD_OFS_MATCH1: rd = {24'h000000, match_w[1]};
      `ETD_OFS_STAT1: rd = {23'h000000, ff_w[1], cnt_w[1]};
      `ETD_OFS_PRESRC: rd = {31'h00000000, presrc_q};
      default: known = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc;
      pslverr <= acc & ~known;
      if (acc && !pwrite) begin
        prdata <= rd;
      end
    end
  end

endmodule // etd_timer
`default_nettype wire

// [hw/etd_defines.vh]
/*
 * Constants for the two-channel 8-bit timer, event counter and divider block.
 * Assumes inclusion by bare name from the design file only.
 */
`ifndef ETD_DEFINES_VH
`define ETD_DEFINES_VH

// Register byte offsets, per channel, then the shared prescale source select.
`define ETD_OFS_CTRL0 12'h000
`define ETD_OFS_MATCH0 12'h004
`define ETD_OFS_STAT0 12'h008
`define ETD_OFS_CTRL1 12'h010
`define ETD_OFS_MATCH1 12'h014
`define ETD_OFS_STAT1 12'h018
`define ETD_OFS_PRESRC 12'h020

// Control byte field positions.
`define ETD_CK_LSB 4
`define ETD_CK_MSB 6
`define ETD_RUN_BIT 3
`define ETD_MODE_LSB 0
`define ETD_MODE_MSB 2
`define ETD_FF_BIT 7

// Field codes.
`define ETD_MODE_TIMER 3'h0
`define ETD_MODE_DIV 3'h1
`define ETD_CK_PIN 3'h7

// Reset values.
`define ETD_CTRL_RST 8'h00
`define ETD_MATCH_RST 8'hFF

`endif

// [test/etd_timer_assertions.sv]
/* Port checker for the timer block.
   Assumes it is bound to etd_timer. */
`timescale 1ns/1ps
`default_nettype none
module etd_chk (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins.
  input wire logic [1:0] divider_out_pin_n,
  input wire logic [1:0] match_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  rdy_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no ready");
  rdy_cause_a: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
  rdy_pulse_a: assert property (pready |=> !pready) else $error("long ready");
  rdy_idle_a: assert property (!psel |-> !pready) else $error("idle ready");
  err_rdy_a: assert property (pslverr |-> pready) else $error("stray error");
  rd_hold_a: assert property ($changed(prdata) |-> pready) else $error("read data moved");
  pin_zero_a: assert property ($changed(divider_out_pin_n[0]) |-> match_irq[0] ||
    $past(match_irq[0]) || $past(match_irq[0], 2) || $past(psel) || $past(psel, 2))
    else $error("pin 0 moved");
  pin_one_a: assert property ($changed(divider_out_pin_n[1]) |-> match_irq[1] ||
    $past(match_irq[1]) || $past(match_irq[1], 2) || $past(psel) || $past(psel, 2))
    else $error("pin 1 moved");
endmodule // etd_chk
bind etd_timer etd_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .divider_out_pin_n(divider_out_pin_n), .match_irq(match_irq));
`default_nettype wire

// [test/etd_evt.sv]
/* External event source for channel 0.
   Assumes en is driven on the rising edge; idle lines rest high. */
`timescale 1ns/1ps
`default_nettype none
module etd_evt (
  // Clock and control.
  input wire logic pclk,
  input wire logic en,
  // Event pins.
  output logic [1:0] pin
);
  logic [6:0] c = 7'h00;
  always @(posedge pclk) if (en) c <= c + 7'h01;
  // Each level lasts four machine cycles.
  assign pin = {1'b1, ~c[2]};
endmodule // etd_evt
`default_nettype wire

// [test/tb.sv]
/* Testbench for the timer block.
   Assumes the checker is bound and etd_evt drives the event pins. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rv;
  logic tick = 1'b0, evt_en = 1'b0, re, p1 = 1'b1, hold;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [1:0] pin_n, irq, evt;
  int n_mismatch = 0, tests_run = 0, cnt[3] = '{0, 0, 0};
  etd_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .main_osc_tick(tick), .sub_osc_tick(1'b0), .event_in_pin(evt),
    .divider_out_pin_n(pin_n), .match_irq(irq));
  etd_evt src (.pclk(pclk), .en(evt_en), .pin(evt));
  initial forever #2 pclk = ~pclk;
  always @(posedge pclk) tick <= ~tick;
  always @(posedge pclk) begin
    if (irq[0]) cnt[0]++;
    if (pin_n[1] !== p1) cnt[1]++;
    if (irq[1]) cnt[2]++;
    p1 = pin_n[1];
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) n_mismatch++;
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic waitc(input int k);
    int i;
    i = 0;
    while (cnt[k] == 0 && i < 3000) begin
      @(posedge pclk);
      i++;
    end
    if (cnt[k] == 0) n_mismatch++;
  endtask
  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #60000;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("pin_rst", 32'h3, {30'h0, pin_n});
    xfer(1'b0, 12'h004, 32'h0);
    chk("match_rst", 32'hFF, {24'h0, rv[7:0]});
    xfer(1'b0, 12'hFFC, 32'h0);
    chk("slverr", 32'h1, {31'h0, re});
    xfer(1'b1, 12'h020, 32'h1);
    xfer(1'b0, 12'h020, 32'h0);
    chk("presrc", 32'h1, {31'h0, rv[0]});
    xfer(1'b1, 12'h020, 32'h0);
    xfer(1'b1, 12'h004, 32'h2);
    xfer(1'b1, 12'h000, 32'h10);
    cnt[0] = 0;
    xfer(1'b1, 12'h000, 32'h18);
    waitc(0);
    cnt[0] = 0;
    repeat (1100) @(posedge pclk);
    chk("irq_timer", 32'h2, cnt[0]);
    xfer(1'b1, 12'h000, 32'h10);
    xfer(1'b0, 12'h008, 32'h0);
    chk("cnt_stop", 32'h0, {23'h0, rv[8:0]});
    xfer(1'b1, 12'h014, 32'h1);
    xfer(1'b1, 12'h010, 32'h11);
    xfer(1'b1, 12'h010, 32'h19);
    cnt[1] = 0;
    waitc(1);
    cnt[1] = 0;
    cnt[2] = 0;
    repeat (1000) @(posedge pclk);
    chk("div_toggles", 32'h3, cnt[1]);
    chk("div_irqs", 32'h3, cnt[2]);
    xfer(1'b1, 12'h010, 32'h11);
    repeat (2) @(posedge pclk);
    hold = pin_n[1];
    repeat (600) @(posedge pclk);
    chk("pin_hold", {31'h0, hold}, {31'h0, pin_n[1]});
    xfer(1'b1, 12'h010, 32'h11);
    repeat (3) @(posedge pclk);
    chk("pin_high", 32'h1, {31'h0, pin_n[1]});
    xfer(1'b1, 12'h010, 32'h91);
    repeat (3) @(posedge pclk);
    chk("pin_low", 32'h0, {31'h0, pin_n[1]});
    xfer(1'b1, 12'h004, 32'h3);
    xfer(1'b1, 12'h000, 32'h70);
    xfer(1'b1, 12'h000, 32'h78);
    cnt[0] = 0;
    evt_en <= 1'b1;
    repeat (72) @(posedge pclk);
    evt_en <= 1'b0;
    repeat (10) @(posedge pclk);
    chk("irq_event", 32'h3, cnt[0]);
    xfer(1'b0, 12'h008, 32'h0);
    chk("cnt_event", 32'h0, {23'h0, rv[8:0]});
    end_of_test;
  end
endmodule // tb
`default_nettype wire
